// ==== core/sbb_pkg.sv ====
// Constants, register map and state encodings for the serial byte access
// block. Assumes an 8-bit configuration port and a 125 MHz core clock.
//
// Summary of operation
// - A read cycle leaves its byte in the data register once busy clears.
// - The index register is sent as the byte address inside the target.
// - Writing the target register while enabled and not busy launches one cycle with the written fields.
// - The target register resets to A0h: EEPROM address, write direction.
// - Target register bits 7:1 carry the 7-bit address sent on the bus.
// - Target register bit 0 selects direction: 0 write, 1 read.
// - Data, index and target registers return to defaults on reset.
// - Control register resets to zero and mixes rw, ro, w1c, hw bits.
// - Control bit 5 is high while a requested bus cycle runs.
// - Control bit 7: 0 sends address then index, 1 sends address only.
// - Control bit 3 enables the bus; set by strap detect or software.
package sbb_pkg;

    // ----------------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0] OFS_DATA   = 8'hB0;
    localparam logic [7:0] OFS_INDEX  = 8'hB1;
    localparam logic [7:0] OFS_TARGET = 8'hB2;
    localparam logic [7:0] OFS_CTRL   = 8'hB3;

    localparam logic [7:0] RST_DATA   = 8'h00;
    localparam logic [7:0] RST_INDEX  = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'hA0;
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ----------------------------------------------------------------------
    // Control register field positions
    // ----------------------------------------------------------------------
    localparam int CTRL_FORM_BIT   = 7;
    localparam int CTRL_BUSY_BIT   = 5;
    localparam int CTRL_ENABLE_BIT = 3;
    localparam int CTRL_NAK_BIT    = 1;
    localparam int TARGET_RW_BIT   = 0;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int CLK_MHZ        = 125;
    localparam int SCL_QUARTER_NS = 2500;
    localparam int QUARTER_CYC    = (SCL_QUARTER_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] STRAP_SAMPLE = 2'h2;
    localparam logic [3:0] ACK_BIT      = 4'h8;

    // ----------------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------------
    typedef enum logic [3:0] {
        SBB_IDLE  = 4'h1,
        SBB_START = 4'h2,
        SBB_BIT   = 4'h4,
        SBB_STOP  = 4'h8
    } sbb_state_e;

    typedef enum logic [4:0] {
        SBB_STG_ADDR1 = 5'h01,
        SBB_STG_INDEX = 5'h02,
        SBB_STG_ADDR2 = 5'h04,
        SBB_STG_WDATA = 5'h08,
        SBB_STG_RDATA = 5'h10
    } sbb_stage_e;

endpackage

// ==== core/sbb_sync2.sv ====
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
module sbb_sync2 #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta     <= RST;
            sync_out <= RST;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ==== core/sbb_quarter_tick.sv ====
// Quarter-bit tick generator for the two-wire bus.
// Assumes run is held high for the whole of a bus cycle.
`timescale 1ns/10ps
module sbb_quarter_tick #(
    parameter int CYC = sbb_pkg::QUARTER_CYC,
    parameter int W   = 16
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic run,
    output logic      tick
);
    localparam logic [W-1:0] LAST = W'(CYC - 1);

    logic [W-1:0] cnt;

    always_ff @(posedge clk)
    begin
        if (sys_rst || !run)
        begin
            cnt  <= '0;
            tick <= 1'b0;
        end
        else if (cnt == LAST)
        begin
            cnt  <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt  <= cnt + W'(1);
            tick <= 1'b0;
        end
    end

    a_tick_single: assert property (@(posedge clk) disable iff (sys_rst)
        tick && run |=> !tick)
        else $error("quarter tick lasted more than one cycle");
endmodule

// ==== core/sbb_top.sv ====
// Single-byte two-wire bus access with configuration-space registers.
// Assumes byte-wide config reads and writes and open-drain bus pins.
`timescale 1ns/10ps
module sbb_top #(
    parameter int QUARTER_CYC = sbb_pkg::QUARTER_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       eeprom_strap,
    input  wire logic [7:0] cfg_addr,
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_wdata,
    input  wire logic       cfg_rd,
    output logic      [7:0] cfg_rdata,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);
    // ----------------------------------------------------------------------
    // Byte selection
    // ----------------------------------------------------------------------
    function automatic logic [7:0] sbb_byte_for(
        input sbb_pkg::sbb_stage_e stg,
        input logic [6:0]          addr,
        input logic                rw,
        input logic                form,
        input logic [7:0]          idx,
        input logic [7:0]          dat
    );
        logic [7:0] b;
        b = 8'h00;
        case (stg)
            sbb_pkg::SBB_STG_ADDR1: b = {addr, form & rw};
            sbb_pkg::SBB_STG_INDEX: b = idx;
            sbb_pkg::SBB_STG_ADDR2: b = {addr, 1'b1};
            sbb_pkg::SBB_STG_WDATA: b = dat;
            default:                b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic sbb_pkg::sbb_stage_e sbb_next_stage(
        input sbb_pkg::sbb_stage_e stg,
        input logic                form,
        input logic                rw
    );
        sbb_pkg::sbb_stage_e n;
        n = stg;
        case (stg)
            sbb_pkg::SBB_STG_ADDR1:
                if (!form)
                    n = sbb_pkg::SBB_STG_INDEX;
                else if (rw)
                    n = sbb_pkg::SBB_STG_RDATA;
                else
                    n = sbb_pkg::SBB_STG_WDATA;
            sbb_pkg::SBB_STG_INDEX:
                n = rw ? sbb_pkg::SBB_STG_ADDR2 : sbb_pkg::SBB_STG_WDATA;
            sbb_pkg::SBB_STG_ADDR2: n = sbb_pkg::SBB_STG_RDATA;
            default:                n = stg;
        endcase
        return n;
    endfunction

    // ----------------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------------
    logic [7:0]          data_reg;
    logic [7:0]          index_reg;
    logic [7:0]          target_reg;
    logic                form;
    logic                enable;
    logic                nak;
    logic                busy;
    logic [1:0]          strap_cnt;
    logic [2:0]          pins_s;
    logic                sda_s;
    logic                scl_s;
    logic                strap_s;
    logic                tick;
    logic                step;
    logic                end_q;
    sbb_pkg::sbb_state_e state;
    sbb_pkg::sbb_stage_e stage;
    sbb_pkg::sbb_stage_e stage_after;
    logic [1:0]          q;
    logic [3:0]          bit_cnt;
    logic [7:0]          shift;
    logic                ack_nak;
    logic [6:0]          copy_addr;
    logic                copy_rw;
    logic                copy_form;
    logic [7:0]          copy_index;
    logic [7:0]          copy_data;
    logic                wr_data;
    logic                wr_index;
    logic                wr_target;
    logic                wr_ctrl;
    logic                launch;
    logic                rx_stage;
    logic                rx_done;
    logic                nak_set;
    logic                next_scl_oe;
    logic                next_sda_oe;
    logic                tx_drive_low;
    logic [7:0]          ctrl_value;

    // ----------------------------------------------------------------------
    // Pin synchronisers and bit timing
    // ----------------------------------------------------------------------
    sbb_sync2 #(
        .W   (3),
        .RST (3'h3)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({eeprom_strap, scl_in, sda_in}),
        .sync_out (pins_s)
    );

    assign sda_s   = pins_s[0];
    assign scl_s   = pins_s[1];
    assign strap_s = pins_s[2];

    sbb_quarter_tick #(
        .CYC (QUARTER_CYC),
        .W   (16)
    ) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (state != sbb_pkg::SBB_IDLE),
        .tick    (tick)
    );

    // Clock stretching: the high phase waits until SCL is seen high
    assign step  = tick && (q != 2'h1 || scl_s);
    assign end_q = step && q == 2'h3;

    // ----------------------------------------------------------------------
    // Register access decode
    // ----------------------------------------------------------------------
    assign wr_data   = cfg_wr && cfg_addr == sbb_pkg::OFS_DATA;
    assign wr_index  = cfg_wr && cfg_addr == sbb_pkg::OFS_INDEX;
    assign wr_target = cfg_wr && cfg_addr == sbb_pkg::OFS_TARGET;
    assign wr_ctrl   = cfg_wr && cfg_addr == sbb_pkg::OFS_CTRL;
    assign launch    = wr_target && enable && !busy;

    assign rx_stage    = stage == sbb_pkg::SBB_STG_RDATA;
    assign stage_after = sbb_next_stage(stage, copy_form, copy_rw);
    assign rx_done     = state == sbb_pkg::SBB_BIT && rx_stage
                         && end_q && bit_cnt == 4'h7;
    assign nak_set     = state == sbb_pkg::SBB_BIT && !rx_stage && end_q
                         && bit_cnt == sbb_pkg::ACK_BIT && ack_nak;
    assign tx_drive_low = bit_cnt < sbb_pkg::ACK_BIT && !rx_stage
                          && !shift[7];
    assign ctrl_value  = {form, 1'b0, busy, 1'b0, enable, 1'b0, nak, 1'b0};

    // ----------------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            data_reg   <= sbb_pkg::RST_DATA;
            index_reg  <= sbb_pkg::RST_INDEX;
            target_reg <= sbb_pkg::RST_TARGET;
        end
        else
        begin
            if (rx_done)
                data_reg <= shift;
            else if (wr_data)
                data_reg <= cfg_wdata;
            if (wr_index)
                index_reg <= cfg_wdata;
            if (wr_target)
                target_reg <= cfg_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            form      <= sbb_pkg::RST_CTRL[sbb_pkg::CTRL_FORM_BIT];
            enable    <= sbb_pkg::RST_CTRL[sbb_pkg::CTRL_ENABLE_BIT];
            nak       <= sbb_pkg::RST_CTRL[sbb_pkg::CTRL_NAK_BIT];
            strap_cnt <= 2'h0;
        end
        else
        begin
            if (strap_cnt != 2'h3)
                strap_cnt <= strap_cnt + 2'h1;
            if (wr_ctrl)
                form <= cfg_wdata[sbb_pkg::CTRL_FORM_BIT];
            if (strap_cnt == sbb_pkg::STRAP_SAMPLE && strap_s)
                enable <= 1'b1;
            else if (wr_ctrl)
                enable <= cfg_wdata[sbb_pkg::CTRL_ENABLE_BIT];
            if (nak_set)
                nak <= 1'b1;
            else if (wr_ctrl && cfg_wdata[sbb_pkg::CTRL_NAK_BIT])
                nak <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cfg_rdata <= sbb_pkg::RD_UNMAPPED;
        else if (cfg_rd)
        begin
            case (cfg_addr)
                sbb_pkg::OFS_DATA:   cfg_rdata <= data_reg;
                sbb_pkg::OFS_INDEX:  cfg_rdata <= index_reg;
                sbb_pkg::OFS_TARGET: cfg_rdata <= target_reg;
                sbb_pkg::OFS_CTRL:   cfg_rdata <= ctrl_value;
                default:             cfg_rdata <= sbb_pkg::RD_UNMAPPED;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Cycle parameters captured at launch
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            copy_addr  <= sbb_pkg::RST_TARGET[7:1];
            copy_rw    <= sbb_pkg::RST_TARGET[sbb_pkg::TARGET_RW_BIT];
            copy_form  <= 1'b0;
            copy_index <= sbb_pkg::RST_INDEX;
            copy_data  <= sbb_pkg::RST_DATA;
        end
        else if (launch)
        begin
            copy_addr  <= cfg_wdata[7:1];
            copy_rw    <= cfg_wdata[sbb_pkg::TARGET_RW_BIT];
            copy_form  <= form;
            copy_index <= index_reg;
            copy_data  <= data_reg;
        end
    end

    // ----------------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state   <= sbb_pkg::SBB_IDLE;
            stage   <= sbb_pkg::SBB_STG_ADDR1;
            q       <= 2'h0;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            ack_nak <= 1'b0;
            busy    <= 1'b0;
        end
        else
        begin
            if (step)
                q <= q + 2'h1;
            case (state)
                sbb_pkg::SBB_IDLE:
                    if (launch)
                    begin
                        state <= sbb_pkg::SBB_START;
                        stage <= sbb_pkg::SBB_STG_ADDR1;
                        q     <= 2'h0;
                        busy  <= 1'b1;
                    end
                sbb_pkg::SBB_START:
                    if (end_q)
                    begin
                        state   <= sbb_pkg::SBB_BIT;
                        bit_cnt <= 4'h0;
                        shift   <= sbb_byte_for(stage, copy_addr, copy_rw,
                                       copy_form, copy_index, copy_data);
                    end
                sbb_pkg::SBB_BIT:
                begin
                    if (step && q == 2'h2)
                    begin
                        if (bit_cnt == sbb_pkg::ACK_BIT)
                            ack_nak <= sda_s;
                        else if (rx_stage)
                            shift <= {shift[6:0], sda_s};
                    end
                    if (end_q && bit_cnt != sbb_pkg::ACK_BIT)
                    begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (!rx_stage)
                            shift <= {shift[6:0], 1'b0};
                    end
                    else if (end_q)
                    begin
                        bit_cnt <= 4'h0;
                        stage   <= stage_after;
                        if (rx_stage || stage == sbb_pkg::SBB_STG_WDATA
                            || ack_nak)
                            state <= sbb_pkg::SBB_STOP;
                        else if (stage_after == sbb_pkg::SBB_STG_ADDR2)
                            state <= sbb_pkg::SBB_START;
                        else
                            shift <= sbb_byte_for(stage_after, copy_addr,
                                         copy_rw, copy_form, copy_index,
                                         copy_data);
                    end
                end
                sbb_pkg::SBB_STOP:
                    if (end_q)
                    begin
                        state <= sbb_pkg::SBB_IDLE;
                        busy  <= 1'b0;
                    end
                default:
                    state <= sbb_pkg::SBB_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Open-drain pin drive
    // ----------------------------------------------------------------------
    always_comb
    begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        case (state)
            sbb_pkg::SBB_START:
            begin
                next_scl_oe = q == 2'h0 || q == 2'h3;
                next_sda_oe = q[1];
            end
            sbb_pkg::SBB_BIT:
            begin
                next_scl_oe = q == 2'h0 || q == 2'h3;
                next_sda_oe = tx_drive_low;
            end
            sbb_pkg::SBB_STOP:
            begin
                next_scl_oe = q == 2'h0;
                next_sda_oe = !q[1];
            end
            default:
            begin
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            scl_oe  <= next_scl_oe;
            sda_oe  <= next_sda_oe;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    a_launch_busy: assert property (@(posedge clk) disable iff (sys_rst)
        launch |=> busy && state == sbb_pkg::SBB_START)
        else $error("launch did not start a busy cycle");

    a_reset_values: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> target_reg == 8'hA0 && data_reg == 8'h00
                           && index_reg == 8'h00)
        else $error("register defaults wrong after reset");

    a_ctrl_reset: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> ctrl_value == 8'h00)
        else $error("control register not zero after reset");

    a_addr_byte: assert property (@(posedge clk) disable iff (sys_rst)
        state == sbb_pkg::SBB_START && end_q
        && stage == sbb_pkg::SBB_STG_ADDR1
        |=> shift == {copy_addr, copy_form & copy_rw})
        else $error("address byte does not match target fields");

    a_index_byte: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(stage == sbb_pkg::SBB_STG_INDEX) |-> shift == copy_index)
        else $error("index byte not taken from index register");

    a_form_skip: assert property (@(posedge clk) disable iff (sys_rst)
        busy && copy_form |-> stage != sbb_pkg::SBB_STG_INDEX)
        else $error("index byte sent in address-only form");

    a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
        rx_done |=> data_reg == $past(shift))
        else $error("read byte not stored in data register");

    // Cycles from read capture to busy clear: ack bit, stop, margin
    localparam logic [15:0] RX_TAIL_MAX = 16'(12 * QUARTER_CYC);

    logic [15:0] rx_tail;

    always_ff @(posedge clk)
    begin
        if (sys_rst || !busy)
            rx_tail <= 16'h0000;
        else if (rx_done || rx_tail != 16'h0000)
            rx_tail <= rx_tail + 16'h0001;
    end

    a_read_tail: assert property (@(posedge clk) disable iff (sys_rst)
        rx_tail <= RX_TAIL_MAX)
        else $error("busy did not clear after read byte capture");

    a_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
        wr_target && !enable && !busy |=> !busy)
        else $error("cycle launched while bus disabled");

    a_idle_pins: assert property (@(posedge clk) disable iff (sys_rst)
        !busy |-> !scl_oe && !sda_oe)
        else $error("bus driven outside a cycle");

    a_nak_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        nak_set |=> nak)
        else $error("no-acknowledge flag lost");
endmodule

// ==== sim/sbb_eeprom_model.sv ====
// Two-wire byte target with a 256-byte store and auto-increment pointer.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/10ps
module sbb_eeprom_model #(
    parameter logic [6:0] DEV = 7'h50
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic no_index,
    output logic      sda_oe
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       act;
    logic       rd;
    logic       hit;
    int         cnt;
    int         nb;

    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'hFF;
        {sda_oe, act, rd, hit, ptr, sh, cnt, nb} = '0;
    end

    always @(negedge sda)
        if (scl)
            {act, rd, cnt, nb} = {1'b1, 65'd0};
    always @(posedge sda)
        if (scl)
            act = 1'b0;
    always @(posedge scl)
        if (act)
        begin
            if (!rd && cnt < 8)
                sh = {sh[6:0], sda};
            cnt++;
        end
    // Acknowledge, byte handling and read data, all off the falling clock
    always @(negedge scl)
        if (act)
        begin
            if (cnt == 8)
                sda_oe = !rd && (nb == 0 ? sh[7:1] == DEV : hit);
            else if (cnt == 9)
            begin
                sda_oe = 1'b0;
                cnt = 0;
                if (!rd)
                begin
                    if (nb == 0)
                    begin
                        hit = sh[7:1] == DEV;
                        rd = hit && sh[0];
                    end
                    else if (nb == 1 && !no_index)
                        ptr = sh;
                    else if (hit)
                    begin
                        mem[ptr] = sh;
                        ptr++;
                    end
                    nb++;
                    if (rd)
                    begin
                        sh = mem[ptr];
                        ptr++;
                        sda_oe = !sh[7];
                    end
                end
            end
            else if (rd && cnt < 8)
                sda_oe = !sh[7 - cnt];
        end
endmodule

// ==== sim/sbb_top_tb.sv ====
// Register-level bench for the serial byte access block.
// Assumes the target model answers at address 50h.
`timescale 1ns/10ps
module sbb_top_tb;
    logic       clk;
    logic       sys_rst;
    logic       eeprom_strap;
    logic [7:0] cfg_addr;
    logic       cfg_wr;
    logic [7:0] cfg_wdata;
    logic       cfg_rd;
    logic [7:0] cfg_rdata;
    logic       scl_out;
    logic       scl_oe;
    logic       sda_out;
    logic       sda_oe;
    logic       mdl_oe;
    logic       no_index;
    logic [7:0] rv;
    int         mismatches;
    int         num_checks;
    wire        scl_w = !scl_oe;
    wire        sda_w = !(sda_oe || mdl_oe);

    initial
        clk = 1'b0;
    always #4 clk = ~clk;

    sbb_top #(.QUARTER_CYC(4)) sbb_top_i (.clk(clk), .sys_rst(sys_rst),
        .eeprom_strap(eeprom_strap), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe));
    sbb_eeprom_model sbb_eeprom_model_i (.scl(scl_w), .sda(sda_w),
        .no_index(no_index), .sda_oe(mdl_oe));

    // ----
    // Access tasks
    // ----
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_addr  <= a;
        cfg_wdata <= d;
        cfg_wr    <= 1'b1;
        @(posedge clk);
        cfg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd   <= 1'b1;
        @(posedge clk);
        cfg_rd   <= 1'b0;
        @(negedge clk);
        d = cfg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // Poll busy with a bound; a hung cycle counts against the run
    task automatic wait_idle;
        int n;
        for (n = 0; n < 1000; n++)
        begin
            rd(8'hB3, rv);
            if (rv[5] === 1'b0)
                break;
        end
        if (n == 1000)
            mismatches++;
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test;
    end

    initial
    begin
        {eeprom_strap, cfg_addr, cfg_wr, cfg_wdata, cfg_rd, no_index} = '0;
        sys_rst = 1'b1;
        mismatches = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(8'hB0, 8'h00);
        rchk(8'hB1, 8'h00);
        rchk(8'hB2, 8'hA0);
        rchk(8'hB3, 8'h00);
        rchk(8'hB4, 8'h00);
        wr(8'hB2, 8'hA0);
        rchk(8'hB3, 8'h00);
        wr(8'hB3, 8'h08);
        rchk(8'hB3, 8'h08);
        wr(8'hB0, 8'h5A);
        wr(8'hB1, 8'hFF);
        wr(8'hB2, 8'hA0);
        rchk(8'hB3, 8'h28);
        chk({6'h00, scl_out, sda_out}, 8'h00);
        wait_idle;
        chk(sbb_eeprom_model_i.mem[8'hFF], 8'h5A);
        rchk(8'hB2, 8'hA0);
        wr(8'hB0, 8'h00);
        wr(8'hB2, 8'hA1);
        wait_idle;
        rchk(8'hB0, 8'h5A);
        no_index <= 1'b1;
        wr(8'hB3, 8'h88);
        wr(8'hB0, 8'h77);
        wr(8'hB2, 8'hA0);
        wait_idle;
        chk(sbb_eeprom_model_i.mem[8'h00], 8'h77);
        wr(8'hB2, 8'hA1);
        wait_idle;
        rchk(8'hB0, 8'hFE);
        wr(8'hB2, 8'h44);
        wait_idle;
        rchk(8'hB3, 8'h8A);
        wr(8'hB3, 8'h8A);
        rchk(8'hB3, 8'h88);
        @(posedge clk);
        eeprom_strap <= 1'b1;
        sys_rst      <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(8'hB3, 8'h08);
        rchk(8'hB0, 8'h00);
        rchk(8'hB1, 8'h00);
        rchk(8'hB2, 8'hA0);
        finish_test;
    end
endmodule
